// [logic/iru_cfg.svh]
// constants of the vectored priority irq unit: offsets, field positions, reset values
// assumes inclusion by the unit's package and design file only
`ifndef IRU_CFG_SVH
`define IRU_CFG_SVH

// ==========================================
// register map (register page, byte offsets inside it; exit offset from the vector base)
`define IRU_REG_PAGE 12'hfff
`define IRU_OFF_CTRL 12'h000
`define IRU_OFF_LEVEL 12'h004
`define IRU_OFF_ENC_PRIO 12'h008
`define IRU_OFF_ENC_SRC 12'h00c
`define IRU_OFF_VBASE 12'h010
`define IRU_NODE_BASE 12'h400
`define IRU_TABLE_BASE 12'h800
`define IRU_EXIT_OFS 9'h100

// ==========================================
// fields
`define IRU_GE_BIT 7
`define IRU_TE_BIT 6
`define IRU_M_BIT 7
`define IRU_P_BIT 6
`define IRU_E_BIT 5
`define IRU_RUN_LSB 4
`define IRU_VBASE_LSB 9

// ==========================================
// reset values and sizes
`define IRU_CTRL_RST 1'b0
`define IRU_PRIO_NONE 4'h0
`define IRU_PRIO_MAX 4'hf
`define IRU_STACK_DEPTH 15

`endif

// [logic/iru_pkg.sv]
// types shared by the irq unit
// assumes iru_cfg.svh is on the include path
`include "iru_cfg.svh"

package iru_pkg;
  typedef logic [3:0] iru_prio_t;

  // winner of the priority encoder
  typedef struct packed {
    logic [5:0] src;
    iru_prio_t prio;
  } iru_enc_t;
endpackage

// [logic/iru_unit.sv]
// vectored priority irq unit: source nodes, encoder, comparator, level stack, vector slots
// assumes sources and the standby bit come from logic on CLK; a plain register port
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "iru_cfg.svh"

module iru_unit #(
  parameter int NODES = 40
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic UNIT_STANDBY,
  input wire logic [NODES-1:1] SRC_IN,
  input wire logic [23:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic CPU_IRQ_REQUEST_N,
  output logic [3:0] ACTIVE_LEVEL
);

  // ==========================================
  // state
  typedef struct packed {
    logic [NODES-1:0] pending;
    logic [NODES-1:0] enable;
    logic [NODES-1:0][3:0] prio;
    logic [NODES-1:1] src_prev;
    logic ge;
    logic te;
    iru_pkg::iru_prio_t forced;
    iru_pkg::iru_prio_t forced_eff;
    iru_pkg::iru_prio_t running;
    logic [`IRU_STACK_DEPTH-1:0][3:0] stack;
    logic [3:0] sp;
    logic irq;
    logic [14:0] vbase;
    logic [NODES-1:0][31:0] vec_table;
    logic [31:0] rdata;
  } iru_state_t;

  iru_state_t s_reg;
  iru_state_t s_next;

  // node or table slot from a register offset: {hit, index}
  function automatic logic [6:0] slot_of(input logic [11:0] off, input logic [11:0] base);
    slot_of = (off[11:8] == base[11:8]) ? {1'b1, off[7:2]} : 7'h00;
  endfunction

  // ==========================================
  // encoder and comparator
  iru_pkg::iru_enc_t best;
  iru_pkg::iru_prio_t level_eff;
  logic cmp;
  logic [5:0] win_src;

  always_comb begin
    best = '0;
    for (int i = NODES - 1; i >= 0; i--) begin
      // offered priority is zero unless enabled and pending
      if (s_reg.enable[i] && s_reg.pending[i] && s_reg.prio[i] != `IRU_PRIO_NONE &&
          s_reg.prio[i] >= best.prio) begin
        best.prio = s_reg.prio[i];
        best.src = 6'(i); // descending scan lets the lowest number win ties
      end
    end
  end

  // forced level only counts once applied, and never lowers running
  assign level_eff = (s_reg.running > s_reg.forced_eff) ? s_reg.running : s_reg.forced_eff;
  assign cmp = best.prio > level_eff;
  assign win_src = cmp ? best.src : 6'h00;

  // ==========================================
  // bus decode
  logic reg_hit;
  logic [11:0] off;
  logic [6:0] node_slot;
  logic [6:0] tab_slot;
  logic node_ok;
  logic tab_ok;
  logic vec_hit;
  logic exit_hit;
  logic accept;
  logic leave;
  logic [NODES-1:1] fall;

  assign off = ADDR[11:0];
  assign reg_hit = ADDR[23:12] == `IRU_REG_PAGE;
  assign node_slot = slot_of(off, `IRU_NODE_BASE);
  assign tab_slot = slot_of(off, `IRU_TABLE_BASE);
  assign node_ok = reg_hit && node_slot[6] && ({1'b0, node_slot[5:0]} < 7'(NODES));
  assign tab_ok = reg_hit && tab_slot[6] && ({1'b0, tab_slot[5:0]} < 7'(NODES));
  // slots only live while the table logic is on
  assign vec_hit = !reg_hit && s_reg.te && ADDR[23:9] == s_reg.vbase && ADDR[8:0] == 9'h000;
  assign exit_hit = !reg_hit && s_reg.te && ADDR[23:9] == s_reg.vbase &&
                    ADDR[8:0] == `IRU_EXIT_OFS;
  assign accept = RD && vec_hit && UNIT_STANDBY;
  assign leave = WR && exit_hit && UNIT_STANDBY;
  // node zero has no input and never sees an edge
  assign fall = s_reg.src_prev & ~SRC_IN;

  // ==========================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.src_prev = SRC_IN;
    s_next.rdata = 32'h0000_0000;

    // ---- software writes
    if (WR && UNIT_STANDBY) begin
      if (reg_hit && off == `IRU_OFF_CTRL) begin
        s_next.ge = WDATA[`IRU_GE_BIT];
        s_next.te = WDATA[`IRU_TE_BIT];
      end
      if (reg_hit && off == `IRU_OFF_LEVEL) begin
        s_next.forced = WDATA[3:0]; // running nibble is hardware only
      end
      if (reg_hit && off == `IRU_OFF_VBASE) begin
        s_next.vbase = WDATA[23:`IRU_VBASE_LSB];
      end
      if (node_ok) begin
        s_next.enable[node_slot[5:0]] = WDATA[`IRU_E_BIT];
        s_next.prio[node_slot[5:0]] = WDATA[3:0];
        if (WDATA[`IRU_M_BIT]) begin
          s_next.pending[node_slot[5:0]] = WDATA[`IRU_P_BIT];
        end
      end
      if (tab_ok) begin
        s_next.vec_table[tab_slot[5:0]] = WDATA;
      end
    end

    // ---- software reads, answered one cycle later
    if (RD && UNIT_STANDBY) begin
      if (reg_hit && off == `IRU_OFF_CTRL) begin
        s_next.rdata[`IRU_GE_BIT] = s_reg.ge;
        s_next.rdata[`IRU_TE_BIT] = s_reg.te;
      end
      if (reg_hit && off == `IRU_OFF_LEVEL) begin
        s_next.rdata[7:0] = {s_reg.running, s_reg.forced};
      end
      if (reg_hit && off == `IRU_OFF_ENC_PRIO) begin
        s_next.rdata[3:0] = best.prio;
      end
      if (reg_hit && off == `IRU_OFF_ENC_SRC) begin
        s_next.rdata[5:0] = best.src;
      end
      if (reg_hit && off == `IRU_OFF_VBASE) begin
        s_next.rdata[23:`IRU_VBASE_LSB] = s_reg.vbase;
      end
      if (node_ok) begin
        // modify bit always reads zero
        s_next.rdata[`IRU_P_BIT] = s_reg.pending[node_slot[5:0]];
        s_next.rdata[`IRU_E_BIT] = s_reg.enable[node_slot[5:0]];
        s_next.rdata[3:0] = s_reg.prio[node_slot[5:0]];
      end
      if (tab_ok) begin
        s_next.rdata = s_reg.vec_table[tab_slot[5:0]];
      end
      if (vec_hit) begin
        s_next.rdata = s_reg.vec_table[win_src]; // default entry when nothing wins
      end
    end

    // ---- accept: every vector read drops the request, push only with a winner
    if (accept) begin
      s_next.irq = 1'b0;
      if (cmp) begin
        if (s_reg.sp < 4'(`IRU_STACK_DEPTH)) begin
          s_next.stack[s_reg.sp] = s_reg.running;
          s_next.sp = s_reg.sp + 4'h1;
        end
        s_next.running = best.prio;
        s_next.pending[best.src] = 1'b0;
      end
    end else if (!s_reg.irq && s_reg.ge && cmp) begin
      // once high, only an accept or the standby clear lowers it, so disabling waits
      s_next.irq = 1'b1;
    end

    // leave: works with global enable off too
    if (leave) begin
      if (s_reg.sp != 4'h0) begin
        s_next.sp = s_reg.sp - 4'h1;
        s_next.running = s_reg.stack[s_reg.sp - 4'h1];
      end else begin
        s_next.running = `IRU_PRIO_NONE;
      end
    end

    // forced raise is held back while a request is out
    if (!s_reg.irq) begin
      s_next.forced_eff = s_reg.forced;
    end

    // edge sets win over any clear in the same cycle
    for (int i = 1; i < NODES; i++) begin
      if (fall[i]) begin
        s_next.pending[i] = 1'b1;
      end
    end

    // standby clear: everything but pending and edge history back to reset
    if (!UNIT_STANDBY) begin
      s_next.enable = '0;
      s_next.prio = '0;
      s_next.ge = `IRU_CTRL_RST;
      s_next.te = `IRU_CTRL_RST;
      s_next.forced = `IRU_PRIO_NONE;
      s_next.forced_eff = `IRU_PRIO_NONE;
      s_next.running = `IRU_PRIO_NONE;
      s_next.stack = '0;
      s_next.sp = 4'h0;
      s_next.irq = 1'b0;
      s_next.vbase = '0;
      s_next.vec_table = '0;
      // pending keeps its hardware updates
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA = s_reg.rdata;
  assign CPU_IRQ_REQUEST_N = ~s_reg.irq;
  assign ACTIVE_LEVEL = level_eff;
endmodule

// [tb/iru_unit_monitor.sv]
// port checker for the irq unit, bound into every instance of it
// assumes the vector base that the bench programs is VEC
`timescale 1ns/1ps
module iru_unit_monitor #(
  parameter int NODES = 40,
  parameter logic [23:0] VEC = 24'h001000
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic UNIT_STANDBY,
  input wire logic [NODES-1:1] SRC_IN,
  input wire logic [23:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic CPU_IRQ_REQUEST_N,
  input wire logic [3:0] ACTIVE_LEVEL
);
  // =====
  // relations between the ports
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_hold; !CPU_IRQ_REQUEST_N && !RD && UNIT_STANDBY |=> !CPU_IRQ_REQUEST_N; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped without a read");
  property p_stby; !UNIT_STANDBY |=> CPU_IRQ_REQUEST_N && ACTIVE_LEVEL == 4'h0; endproperty
  a_stby: assert property (p_stby) else $error("standby did not clear");
  property p_stby_rd; RD && !UNIT_STANDBY |=> RDATA == 32'h0; endproperty
  a_stby_rd: assert property (p_stby_rd) else $error("read in standby");
  property p_one; !RD |=> RDATA == 32'h0; endproperty
  a_one: assert property (p_one) else $error("read data outside its cycle");
  property p_max;
    ACTIVE_LEVEL == 4'hf && $past(ACTIVE_LEVEL) == 4'hf && CPU_IRQ_REQUEST_N |=> CPU_IRQ_REQUEST_N;
  endproperty
  a_max: assert property (p_max) else $error("irq above top level");
  property p_acc;
    RD && ADDR == VEC && !CPU_IRQ_REQUEST_N && UNIT_STANDBY
      |=> CPU_IRQ_REQUEST_N && ACTIVE_LEVEL > $past(ACTIVE_LEVEL);
  endproperty
  a_acc: assert property (p_acc) else $error("accept failed");
  property p_exit;
    WR && ADDR == VEC + 24'h100 && UNIT_STANDBY |=> ACTIVE_LEVEL <= $past(ACTIVE_LEVEL);
  endproperty
  a_exit: assert property (p_exit) else $error("exit raised the level");
  property p_frz;
    !CPU_IRQ_REQUEST_N && UNIT_STANDBY && !RD && !(WR && ADDR == VEC + 24'h100) |=> $stable(ACTIVE_LEVEL);
  endproperty
  a_frz: assert property (p_frz) else $error("level moved while irq low");
endmodule

bind iru_unit iru_unit_monitor #(.NODES(NODES)) u_mon (.CLK(CLK), .RESET(RESET),
  .UNIT_STANDBY(UNIT_STANDBY), .SRC_IN(SRC_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CPU_IRQ_REQUEST_N(CPU_IRQ_REQUEST_N), .ACTIVE_LEVEL(ACTIVE_LEVEL));

// [tb/iru_cpu_model.sv]
// cpu side of the irq unit: bus cycles and handler exit
// assumes one clock and a slave that never stalls
`timescale 1ns/1ps
module iru_cpu_model #(
  parameter logic [23:0] VEC = 24'h001000
) (
  input wire logic CLK,
  output logic [23:0] ADDR,
  output logic [31:0] WDATA,
  output logic WR,
  output logic RD
);
  // =====
  // bus cycles; released lines show the inverse so stale values are never mistaken
  initial {ADDR, WDATA, WR, RD} = '0;
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    ADDR <= ~a;
    WDATA <= ~d;
  endtask
  task automatic rd(input logic [23:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    ADDR <= ~a;
  endtask
  task automatic leave();
    wr(VEC + 24'h100, 32'h0);
  endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench: registers, nesting, global enable, forcing, random sources
// assumes the cpu model drives the bus and the monitor is bound to the unit
`timescale 1ns/1ps
module tb_top;
  localparam logic [23:0] VEC = 24'h001000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic standby = 1'b0;
  logic [39:1] src = '1;
  logic [23:0] addr;
  logic [31:0] wdata, rdata;
  logic wr, rd, irq_n, rd_d = 1'b0;
  logic [3:0] lvl;
  logic [31:0] exp_q[$];
  int failures = 0, n_compared = 0, seed = 12101, n, p;
  always #5 clk = ~clk;
  iru_cpu_model #(.VEC(VEC)) cpu (.CLK(clk), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd));
  iru_unit uut (.CLK(clk), .RESET(reset), .UNIT_STANDBY(standby), .SRC_IN(src), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CPU_IRQ_REQUEST_N(irq_n), .ACTIVE_LEVEL(lvl));
  // =====
  // checking
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] hv(input int k);
    return 32'h00c00000 + 32'(k);
  endfunction
  task automatic rdc(input logic [23:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    cpu.rd(a);
  endtask
  task automatic lv(input logic [3:0] e);
    #1 chk({28'h0, lvl}, {28'h0, e});
  endtask
  // falling edges on sources a and b, then irq looked at on the latency bound
  task automatic fire(input int a, input int b, input logic e);
    @(posedge clk);
    src[a] <= 1'b0;
    src[b] <= 1'b0;
    @(posedge clk);
    src <= '1;
    @(posedge clk);
    #1 chk({31'h0, irq_n}, {31'h0, e});
  endtask
  always @(posedge clk) begin
    if (rd_d) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_d <= rd;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    results();
  end
  // =====
  // scenarios
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    cpu.wr(24'hfff000, 32'hc0);
    rdc(24'hfff000, 32'h0);
    @(posedge clk);
    standby <= 1'b1;
    rdc(24'hfff000, 32'h0);
    rdc(24'hfff004, 32'h0);
    rdc(VEC, 32'h0);
    rdc(24'hfff8a0, 32'h0);
    cpu.wr(24'hfff010, 32'(VEC));
    for (int i = 0; i < 40; i++) cpu.wr(24'hfff800 + 24'(4 * i), hv(i));
    cpu.wr(24'hfff000, 32'hc0);
    rdc(VEC, hv(0));
    cpu.wr(24'hfff40c, 32'ha5);
    cpu.wr(24'hfff424, 32'ha5);
    cpu.wr(24'hfff430, 32'ha7);
    rdc(24'hfff40c, 32'h25);
    fire(3, 9, 1'b0);
    rdc(24'hfff00c, 32'h3);
    rdc(VEC, hv(3));
    lv(4'h5);
    fire(12, 12, 1'b0);
    rdc(VEC, hv(12));
    lv(4'h7);
    cpu.leave();
    lv(4'h5);
    cpu.leave();
    lv(4'h0);
    repeat (2) @(posedge clk);
    rdc(VEC, hv(9));
    cpu.leave();
    cpu.wr(24'hfff000, 32'h40);
    fire(12, 12, 1'b1);
    rdc(24'hfff430, 32'h67);
    cpu.wr(24'hfff000, 32'hc0);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq_n}, 32'h0);
    rdc(VEC, hv(12));
    cpu.leave();
    cpu.wr(24'hfff004, 32'hf);
    rdc(24'hfff004, 32'hf);
    fire(3, 3, 1'b1);
    cpu.wr(24'hfff004, 32'h0);
    repeat (2) @(posedge clk);
    rdc(VEC, hv(3));
    cpu.leave();
    for (int k = 0; k < 8; k++) begin
      n = 1 + int'($unsigned($random(seed)) % 39);
      p = 1 + int'($unsigned($random(seed)) % 15);
      cpu.wr(24'hfff400 + 24'(4 * n), 32'ha0 | 32'(p));
      fire(n, n, 1'b0);
      rdc(VEC, hv(n));
      lv(4'(p));
      cpu.leave();
      cpu.wr(24'hfff400 + 24'(4 * n), 32'h80);
    end
    repeat (3) @(posedge clk);
    results();
  end
endmodule
